/* File: hw/otsel_defs.vh */
// Shared constants for the trip-timing and selectivity block.
// Assumes the includer is a plain Verilog-2005 design on a 250 MHz clock.
// Function
// [RQ1] Thermal memory only with inverse curve
// [RQ2] Full trip time after memory time elapsed
// [RQ3] Start-up only with fixed curve, disableable
// [RQ4] Start-up swaps thresholds for window time
// [RQ5] Start-up at power-on or peak over 0.1In
// [RQ6] Re-arm only after peak below 0.1In
// [RQ7] Shared window, 0.1 to 1.5 s, 0.01 steps
// [RQ8] Selectivity excluded: output 0, programmed delay
// [RQ9] Selectivity inserted: restraint logic, selectivity time
// [RQ10] Selectivity and directional mutually exclusive
// [RQ11] Programmed delay at least selectivity plus 50ms
// [RQ12] Two independent short-delay sets trip alone
// [RQ13] Directional fixed-time, excludable, phases only
// [RQ14] Direction known only if reactive over 2%
// [RQ15] Power-flow setting defines forward reference
// [RQ16] High-to-low: positive reactive is forward
// [RQ17] Forward over threshold: forward delay trip
// [RQ18] Backward over threshold: backward delay trip
// [RQ19] Undetermined direction: shorter delay trip
// [RQ20] Directional assumes neutral setting 100 percent
// [RQ21] Directional start-up option like short-delay
// [RQ22] Timers run while over, clear below
`ifndef OTSEL_DEFS_VH
`define OTSEL_DEFS_VH
`define OTSEL_CLK_MHZ         8'hFA
// Cycles per ms and per 10 ms at 250 MHz
`define OTSEL_CYC_PER_MS      32'h0003D090
`define OTSEL_CYC_PER_10MS    32'h002625A0
`define OTSEL_WIN_MIN_10MS    8'h0A
`define OTSEL_WIN_MAX_10MS    8'h96
`define OTSEL_MARGIN_MS       17'h00032
`define OTSEL_STARTUP_DIV     4'hA
`define OTSEL_REACT_PCT       2'h2
`define OTSEL_PCT_FULL        7'h64
`define OTSEL_FLOW_HI_LO      1'b0
`endif

/* File: hw/otsel_trip.v */
// Trip-timing logic: short delay with thermal memory and start-up window,
// zone restraint, double short delay and directional short circuit.
// Assumes measurements arrive synchronous to clk from the measurement path;
// the restraint input terminal comes from a far release and is synchronised.
`include "otsel_defs.vh"
module otsel_trip #(
    parameter W   = 24,
    parameter TW  = 32,
    parameter CPM = `OTSEL_CYC_PER_MS,
    parameter CPW = `OTSEL_CYC_PER_10MS
) (
    // Clock and reset
    input  wire          clk,
    input  wire          resetn,
    // Measurements, same clock domain
    input  wire [W-1:0]  imax_peak,
    input  wire [W-1:0]  irated,
    input  wire signed [W-1:0] react_pwr,
    input  wire [W-1:0]  nom_phase_pwr,
    input  wire          self_supply,
    input  wire          aux_supply,
    // Short-delay configuration
    input  wire          sd_enable,
    input  wire          sd_inverse,
    input  wire          sd_mem_enable,
    input  wire [W-1:0]  short_delay_threshold,
    input  wire [W-1:0]  sd_start_threshold,
    input  wire [15:0]   short_delay_time,
    input  wire [15:0]   overload_memory_time,
    input  wire [15:0]   sd_inverse_time,
    input  wire          sd_start_enable,
    // Second short-delay set
    input  wire          sd2_enable,
    input  wire [W-1:0]  sd2_threshold,
    input  wire [W-1:0]  sd2_start_threshold,
    input  wire [15:0]   sd2_time,
    // Zone selectivity
    input  wire          zone_enable,
    input  wire [15:0]   zone_time,
    input  wire          restraint_input_terminal,
    // Directional protection
    input  wire          dir_enable,
    input  wire          flow_setting,
    input  wire [W-1:0]  directional_threshold,
    input  wire [W-1:0]  dir_start_threshold,
    input  wire [15:0]   forward_delay,
    input  wire [15:0]   backward_delay,
    input  wire          dir_start_enable,
    // Start-up window, in 10 ms steps
    input  wire [7:0]    start_window_time,
    // Outputs
    output reg           restraint_output_terminal,
    output reg           trip,
    output reg           trip_sd,
    output reg           trip_sd2,
    output reg           trip_dir,
    output reg           startup_active,
    output reg  [1:0]    direction,
    output reg           config_error
);
    localparam DIR_NONE = 2'b00;
    localparam DIR_FWD  = 2'b01;
    localparam DIR_BWD  = 2'b10;

    function [TW-1:0] ms_cycles;
        input [15:0] ms;
        begin
            ms_cycles = ms * CPM;
        end
    endfunction

    function over;
        input [W-1:0] i;
        input [W-1:0] th;
        begin
            over = (i > th);
        end
    endfunction

    reg          zsi_meta;
    reg          zone_restraint_input;
    always @(posedge clk) begin
        if (!resetn) begin
            zsi_meta <= 1'b0;
            zone_restraint_input <= 1'b0;
        end else begin
            zsi_meta <= restraint_input_terminal;
            zone_restraint_input <= zsi_meta;
        end
    end

    // Start-up detection and window
    wire [W-1:0] start_level = irated / `OTSEL_STARTUP_DIV;
    wire         peak_high   = imax_peak > start_level;
    reg          armed;
    reg          powered;
    reg  [TW-1:0] win_cnt;
    wire [7:0]   win_set = (start_window_time < `OTSEL_WIN_MIN_10MS) ?
                           `OTSEL_WIN_MIN_10MS :
                           (start_window_time > `OTSEL_WIN_MAX_10MS) ?
                           `OTSEL_WIN_MAX_10MS : start_window_time; // RQ7
    wire         start_evt = (!powered && self_supply) ||
                             (armed && peak_high); // RQ5
    wire [TW-1:0] win_cycles = win_set * CPW;
    always @(posedge clk) begin
        if (!resetn) begin
            armed <= 1'b1;
            powered <= 1'b0;
            win_cnt <= {TW{1'b0}};
            startup_active <= 1'b0;
        end else begin
            powered <= 1'b1;
            if (peak_high)
                armed <= 1'b0;
            else
                armed <= 1'b1; // RQ6
            if (start_evt) begin
                win_cnt <= win_cycles;
                startup_active <= 1'b1; // RQ4
            end else if (win_cnt != {TW{1'b0}}) begin
                win_cnt <= win_cnt - 1'b1;
                startup_active <= (win_cnt != {{(TW-1){1'b0}}, 1'b1});
            end else begin
                startup_active <= 1'b0;
            end
        end
    end

    // Start-up thresholds only with fixed curve for short delay
    wire sd_start  = startup_active && sd_start_enable && !sd_inverse; // RQ3
    wire dir_start = startup_active && dir_start_enable; // RQ21
    wire [W-1:0] th1 = sd_start ? sd_start_threshold : short_delay_threshold;
    wire [W-1:0] th2 = sd_start ? sd2_start_threshold : sd2_threshold;
    wire [W-1:0] th7 = dir_start ? dir_start_threshold :
                       directional_threshold; // RQ4
    wire over1 = sd_enable && over(imax_peak, th1);
    wire over2 = sd2_enable && over(imax_peak, th2); // RQ12
    // Neutral always counted at full phase setting; phase current only
    wire over7 = dir_enable && !zone_enable &&
                 over(imax_peak, th7); // RQ13 RQ20

    // Direction classification
    // Most negative value maps onto itself, read unsigned it is still right
    wire [W-1:0] q_mag = react_pwr[W-1] ? -react_pwr : react_pwr;
    wire [W+6:0] q_x100 = {{7{1'b0}}, q_mag} * `OTSEL_PCT_FULL;
    wire [W+6:0] p_x2 = {{7{1'b0}}, nom_phase_pwr} * `OTSEL_REACT_PCT;
    wire         q_valid = q_x100 >= p_x2; // RQ14
    wire         q_pos = !react_pwr[W-1];
    wire         in_phase = (flow_setting == `OTSEL_FLOW_HI_LO) ?
                            q_pos : !q_pos; // RQ15 RQ16
    reg  [1:0]   next_direction;
    always @* begin
        if (!q_valid)
            next_direction = DIR_NONE;
        else if (in_phase)
            next_direction = DIR_FWD;
        else
            next_direction = DIR_BWD;
    end

    // Thermal memory: shortened delay while memory time not elapsed
    reg  [TW-1:0] mem_cnt;
    reg           over1_q;
    wire mem_on = sd_mem_enable && sd_inverse; // RQ1
    wire mem_hot = mem_on && (mem_cnt != {TW{1'b0}});
    wire [15:0] base_t1 = sd_inverse ? sd_inverse_time : short_delay_time;
    wire [15:0] eff_t1 = mem_hot ? (base_t1 >> 1) : base_t1; // RQ2
    // Without zone restraint input, selectivity time is selected
    wire zone_ok = zone_enable && !dir_enable && aux_supply; // RQ10
    wire [15:0] sel_t1 = (zone_ok && !zone_restraint_input) ?
                         zone_time : eff_t1; // RQ8 RQ9
    wire [15:0] sel_t7 = (direction == DIR_FWD) ? forward_delay : // RQ17
                         (direction == DIR_BWD) ? backward_delay : // RQ18
                         ((forward_delay < backward_delay) ?
                          forward_delay : backward_delay); // RQ19

    reg [TW-1:0] cnt1;
    reg [TW-1:0] cnt2;
    reg [TW-1:0] cnt7;
    wire [16:0] margin = {1'b0, zone_time} + `OTSEL_MARGIN_MS;
    always @(posedge clk) begin
        if (!resetn) begin
            cnt1 <= {TW{1'b0}};
            cnt2 <= {TW{1'b0}};
            cnt7 <= {TW{1'b0}};
            mem_cnt <= {TW{1'b0}};
            over1_q <= 1'b0;
            trip_sd <= 1'b0;
            trip_sd2 <= 1'b0;
            trip_dir <= 1'b0;
            trip <= 1'b0;
            direction <= DIR_NONE;
            restraint_output_terminal <= 1'b0;
            config_error <= 1'b0;
        end else begin
            direction <= next_direction;
            restraint_output_terminal <= zone_ok &&
                (zone_restraint_input || over1); // RQ8 RQ9
            config_error <= (zone_enable && dir_enable) ||
                (zone_enable && ({1'b0, short_delay_time} < margin)); // RQ11
            over1_q <= over1;
            // Loaded when a fault ends, so a first fault runs full time
            if (over1_q && !over1)
                mem_cnt <= ms_cycles(overload_memory_time); // RQ2
            else if (mem_cnt != {TW{1'b0}})
                mem_cnt <= mem_cnt - 1'b1;
            if (!over1)
                cnt1 <= {TW{1'b0}}; // RQ22
            else if (cnt1 < ms_cycles(sel_t1))
                cnt1 <= cnt1 + 1'b1;
            else
                trip_sd <= 1'b1; // RQ22
            if (!over2)
                cnt2 <= {TW{1'b0}};
            else if (cnt2 < ms_cycles(sd2_time))
                cnt2 <= cnt2 + 1'b1;
            else
                trip_sd2 <= 1'b1; // RQ12
            if (!over7)
                cnt7 <= {TW{1'b0}}; // RQ22
            else if (cnt7 < ms_cycles(sel_t7))
                cnt7 <= cnt7 + 1'b1;
            else
                trip_dir <= 1'b1;
            trip <= trip || trip_sd || trip_sd2 || trip_dir;
        end
    end
endmodule

/* File: test/otsel_trip_chk.sv */
// Port-level assertions for the trip block.
// Assumes one clock and a synchronous active-low reset.
module otsel_trip_chk #(parameter W = 24) (
    input wire clk, resetn, aux_supply, sd_enable, zone_enable, dir_enable,
    input wire flow_setting, restraint_input_terminal, config_error,
    input wire restraint_output_terminal, trip, trip_sd, trip_sd2, trip_dir,
    input wire [W-1:0] imax_peak, short_delay_threshold, sd_start_threshold,
    input wire [W-1:0] nom_phase_pwr,
    input wire signed [W-1:0] react_pwr,
    input wire [1:0] direction
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Five cycles covers the two-stage sync plus the output flop
    sequence s_held;
        (zone_enable && aux_supply && !dir_enable
            && restraint_input_terminal)[*5];
    endsequence
    sequence s_fault;
        $rose(trip_sd);
    endsequence
    AST_ZONE_OFF: assert property (!zone_enable && $past(!zone_enable)
        |-> !restraint_output_terminal) else $error("restraint while off");
    AST_RESTRAIN: assert property (s_held |-> restraint_output_terminal)
        else $error("restraint not relayed");
    AST_TRIP_OR: assert property (trip_sd || trip_sd2 || trip_dir
        |=> trip) else $error("trip missing");
    AST_TRIP_WHY: assert property ($rose(trip)
        |-> $past(trip_sd || trip_sd2 || trip_dir)) else $error("no cause");
    AST_SD_WHY: assert property (s_fault |-> $past(sd_enable
        && (imax_peak > short_delay_threshold
        || imax_peak > sd_start_threshold))) else $error("trip below level");
    AST_FWD: assert property ($past(resetn) && dir_enable
        && !flow_setting && react_pwr > 0
        && react_pwr * 100 >= nom_phase_pwr * 2
        |=> direction == 2'h1) else $error("forward missed");
    AST_UNDET: assert property (react_pwr >= 0
        && react_pwr * 100 < nom_phase_pwr * 2 |=> direction == 2'h0)
        else $error("direction without power");
    AST_EXCL: assert property (zone_enable && dir_enable
        |=> config_error) else $error("options not flagged");
endmodule
bind otsel_trip otsel_trip_chk #(.W(W)) chk_u (.*);

/* File: test/otsel_nbr.sv */
// Downstream release model driving the restraint wire.
// Assumes the bench says when that release sees its own fault.
module otsel_nbr (
    input  wire clk,
    input  wire fault_seen,
    output reg  restraint_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial restraint_out = 1'b0;
    always @(posedge clk) restraint_out <= fault_seen;
endmodule

/* File: test/test_overcurrent_trip_selectivity.sv */
// Bench for the trip block beside a downstream release model.
// Assumes count parameters shrunk so each delay lasts a few cycles.
module test_overcurrent_trip_selectivity;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, resetn = 0, self_supply = 0, aux_supply = 1, nbr = 0;
    logic sd_enable = 1, sd_inverse = 0, sd_mem_enable = 0, sd2_enable = 0;
    logic sd_start_enable = 1, zone_enable = 0, dir_enable = 0;
    logic flow_setting = 0, dir_start_enable = 0;
    logic [23:0] imax_peak = 24'h0, irated = 24'h3E8, nom_phase_pwr = 24'h3E8;
    logic [23:0] short_delay_threshold = 24'h800, sd2_threshold = 24'h800;
    logic [23:0] sd_start_threshold = 24'h800, sd2_start_threshold = 24'h800;
    logic [23:0] directional_threshold = 24'h800, dir_start_threshold = 24'h800;
    logic signed [23:0] react_pwr = 24'sh0;
    logic [15:0] short_delay_time = 16'h5, sd2_time = 16'h3, zone_time = 16'h2;
    logic [15:0] overload_memory_time = 16'h0, sd_inverse_time = 16'h5;
    logic [15:0] forward_delay = 16'h3, backward_delay = 16'h6;
    logic [7:0] start_window_time = 8'h5;
    logic restraint_output_terminal, trip, trip_sd, trip_sd2, trip_dir;
    logic startup_active, config_error;
    logic [1:0] direction;
    wire restraint_input_terminal;
    int err_count = 0, tests_run = 0;
    always #2 clk = ~clk;
    otsel_trip #(.CPM(2), .CPW(3)) dut_u (.*);
    otsel_nbr nbr_u (.clk(clk), .fault_seen(nbr),
        .restraint_out(restraint_input_terminal));
    task check(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task rst;
        resetn = 0;
        imax_peak = 24'h0;
        repeat (10) @(negedge clk);
        resetn = 1;
    endtask
    // Edge counts are 2 per ms here, plus one for the trip flag and one for the sticky summary
    task trip_at(input int n);
        imax_peak = 24'h900;
        repeat (n) @(negedge clk);
        check(trip === 1'b0, "trip early");
        repeat (4) @(negedge clk);
        check(trip === 1'b1, "trip late");
    endtask
    task t_sd;
        rst();
        imax_peak = 24'h900;
        repeat (8) @(negedge clk);
        imax_peak = 24'h100;
        @(negedge clk);
        trip_at(10);
        sd2_enable = 1;
        rst();
        trip_at(6);
        check(trip_sd === 1'b0 && trip_sd2 === 1'b1, "set split");
        sd2_enable = 0;
    endtask
    task t_mem;
        {sd_inverse, sd_mem_enable} = 2'h3;
        overload_memory_time = 16'h8;
        rst();
        trip_at(10);
        rst();
        imax_peak = 24'h900;
        repeat (4) @(negedge clk);
        imax_peak = 24'h100;
        @(negedge clk);
        trip_at(4);
        {sd_inverse, sd_mem_enable} = 2'h0;
        overload_memory_time = 16'h0;
    endtask
    task t_zone;
        zone_enable = 1;
        short_delay_time = 16'h34;
        rst();
        trip_at(4);
        check(restraint_output_terminal === 1'b1, "no restraint");
        nbr = 1;
        rst();
        repeat (5) @(negedge clk);
        trip_at(104);
        dir_enable = 1;
        repeat (2) @(negedge clk);
        check(config_error === 1'b1, "options together");
        {zone_enable, dir_enable, nbr} = 3'h0;
        short_delay_time = 16'h5;
    endtask
    task t_dir;
        logic signed [23:0] rp [4] = '{24'sh100, -24'sh100, 24'sh5, 24'sh100};
        int n [4] = '{6, 12, 6, 12};
        logic [1:0] dv [4] = '{2'h1, 2'h2, 2'h0, 2'h2};
        for (int k = 0; k < 4; k++) begin
            rst();
            {sd_enable, dir_enable, flow_setting} = {2'h1, k == 3};
            react_pwr = rp[k];
            repeat (2) @(negedge clk);
            trip_at(n[k]);
            check(direction === dv[k], "direction");
            check(trip_dir === 1'b1, "no directional trip");
        end
        {sd_enable, dir_enable, flow_setting} = 3'h4;
    endtask
    task st(input int n, input logic e);
        repeat (n) @(negedge clk);
        check(startup_active === e, "start-up window");
    endtask
    task t_start;
        self_supply = 1;
        rst();
        st(2, 1'b1);
        st(20, 1'b1);
        st(16, 1'b0);
        imax_peak = 24'h100;
        st(2, 1'b1);
        st(40, 1'b0);
        imax_peak = 24'h0;
        repeat (2) @(negedge clk);
        imax_peak = 24'h100;
        st(2, 1'b1);
    endtask
    initial begin
        t_sd();
        t_mem();
        t_zone();
        t_dir();
        t_start();
        final_report();
    end
    initial begin
        #20000;
        err_count++;
        final_report();
    end
    task final_report;
        if (err_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
endmodule
